// ---- design/alarm_pkg.sv ----
// Function
// - over-60 alarm latches; clears on reset after correction
// - high alarm: oscillator off, dump open, bias on
// - silence mutes tone only; lamp, dump stay
// - dump opening drives pressure down, low alarm follows
// - low alarm lamp and tone below 5
// - low alarm: oscillator off, dump on, bias on
// - oscillator stays stopped until restarted after clearing
// - power failure latches; reset clears regardless
// - after power reset oscillator needs start press
// - reset clears latches; safety only when corrected
// - source gas low: yellow lamp, no tone
// - battery low: yellow, no tone, lit during reset
// - coil overheated: yellow lamp, no tone, self-clearing
// - enabled but amplitude low: red, tone only
// - silence: 45 s, yellow lamp, not cancellable
// - red alarms sound 3 kHz modulated tone
// - start/stop toggles; enable refused without start-up
package alarm_pkg;
   // timing figures; long intervals are counted in ticks
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_US = 1000;
   localparam int SILENCE_S = 45;
   localparam int TONE_HZ = 3000;
   localparam int MOD_MS = 250;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam int SILENCE_TICKS = SILENCE_S * 1_000_000 / TICK_US;
   localparam int TONE_HALF_CYCLES = CLK_HZ / (2 * TONE_HZ);
   localparam int MOD_TICKS = MOD_MS * 1000 / TICK_US;
   // comparator thresholds, applied by the sensors outside
   localparam int HIGH_PRESS_CMH2O = 60;
   localparam int LOW_PRESS_CMH2O = 5;
   localparam int GAS_LOW_PSIG = 30;
   localparam int COIL_HOT_C = 150;
   // pin input positions in the synchroniser vector
   localparam int IN_HIGH = 0;
   localparam int IN_LOW = 1;
   localparam int IN_MAINS = 2;
   localparam int IN_GAS_BLEND = 3;
   localparam int IN_GAS_COOL = 4;
   localparam int IN_BATT = 5;
   localparam int IN_HOT = 6;
   localparam int IN_AMP = 7;
   localparam int IN_RESET = 8;
   localparam int IN_START = 9;
   localparam int IN_SILENCE = 10;
   localparam int IN_STARTUP_OK = 11;
   localparam int NUM_IN = 12;
   // register byte offsets
   localparam logic [7:0] LIVE_OFS = 8'h00;
   localparam logic [7:0] CTRL_OFS = 8'h04;
   localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
   localparam logic [7:0] IRQ_ENABLE_OFS = 8'h0c;
   localparam logic [7:0] IRQ_CLEAR_OFS = 8'h10;
   localparam logic [31:0] CTRL_RST = 32'h00000001;
   localparam logic [5:0] IRQ_ENABLE_RST = 6'h00;
   localparam int CTRL_MOD_BIT = 0;
   // event bits, same layout in status, enable and clear
   localparam int EV_HIGH = 0;
   localparam int EV_LOW = 1;
   localparam int EV_POWER = 2;
   localparam int EV_STOPPED = 3;
   localparam int EV_CAUTION = 4;
   localparam int EV_SIL_DONE = 5;
   localparam int NUM_EV = 6;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;
endpackage

// ---- design/alarm_supervisor.sv ----
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module alarm_supervisor
   import alarm_pkg::*;
#(
   parameter int TICK_CYC = TICK_CYCLES,
   parameter int SIL_TICKS = SILENCE_TICKS,
   parameter int TONE_HALF = TONE_HALF_CYCLES,
   parameter int MOD_LEN = MOD_TICKS
) (
   input wire logic clk, // system clock
   input wire logic rst, // synchronous reset, active high
   input wire logic press_high, // airway pressure above 60
   input wire logic press_low, // mean_airway_pressure below 5
   input wire logic mains_ok, // mains supply adequate
   input wire logic gas_low_blend, // blender inlet below 30 psig
   input wire logic gas_low_cool, // cooling inlet below 30 psig
   input wire logic batt_low, // backup battery low
   input wire logic coil_hot, // coil near 150 C
   input wire logic amp_low, // oscillation amplitude below threshold
   input wire logic btn_reset, // reset pushbutton, high while held
   input wire logic btn_start, // start/stop pushbutton
   input wire logic btn_silence, // silence pushbutton
   input wire logic startup_ok, // start-up conditions met
   output logic osc_drive, // oscillator drive enable
   output logic osc_enabled, // green lamp
   output logic dump_open, // dump valve command
   output logic bias_flow, // bias flow enable
   output logic red_high, // high pressure lamp
   output logic red_low, // low pressure lamp
   output logic red_power, // power failure lamp
   output logic red_stopped, // oscillator stopped lamp
   output logic yel_gas, // source gas lamp
   output logic yel_batt, // battery lamp
   output logic yel_hot, // overheat lamp
   output logic yel_silence, // silence lamp
   output logic tone, // audible drive
   output logic irq, // interrupt, level
   input wire logic [7:0] awaddr, // axi write address
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr, // axi read address
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready
);
   logic [NUM_IN-1:0] raw, s1, s2, s3, filt, filt_q;
   logic hi_latch, lo_latch, pf_latch;
   logic reset_held, start_press, sil_press, hi_new, lo_new, pf_new;
   logic [31:0] tick_cnt, sil_cnt, tone_cnt, mod_cnt;
   logic tick, sil_active, sil_done, sq, mod_phase, any_red, caution;
   logic [31:0] ctrl;
   logic [NUM_EV-1:0] irq_status, irq_en, events, clr_mask;
   logic aw_got, w_got, do_write;
   logic [7:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;

   assign raw = {startup_ok, btn_silence, btn_start, btn_reset, amp_low, coil_hot,
                 batt_low, gas_low_cool, gas_low_blend, mains_ok, press_low, press_high};

   // three stages per pin; a level is taken once stages two and three agree
   genvar gi;
   generate
      for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
         always_ff @(posedge clk) begin
            if (rst) begin
               s1[gi] <= 1'b0;
               s2[gi] <= 1'b0;
               s3[gi] <= 1'b0;
               filt[gi] <= 1'b0;
               filt_q[gi] <= 1'b0;
            end else begin
               s1[gi] <= raw[gi];
               s2[gi] <= s1[gi];
               s3[gi] <= s2[gi];
               if (s2[gi] == s3[gi]) begin
                  filt[gi] <= s3[gi];
               end
               filt_q[gi] <= filt[gi];
            end
         end
      end
   endgenerate

   // events and held levels derived from filtered pins
   assign reset_held = filt[IN_RESET];
   assign start_press = filt[IN_START] & ~filt_q[IN_START];
   assign sil_press = filt[IN_SILENCE] & ~filt_q[IN_SILENCE];
   assign hi_new = filt[IN_HIGH] & ~hi_latch;
   assign lo_new = filt[IN_LOW] & ~lo_latch;
   assign pf_new = ~filt[IN_MAINS] & filt_q[IN_MAINS];
   assign any_red = hi_latch | lo_latch | pf_latch | red_stopped;
   assign caution = filt[IN_GAS_BLEND] | filt[IN_GAS_COOL] | filt[IN_BATT] | filt[IN_HOT];

   // high pressure latch: set has priority, clears only once corrected
   always_ff @(posedge clk) begin
      if (rst) begin
         hi_latch <= 1'b0;
      end else if (filt[IN_HIGH]) begin
         hi_latch <= 1'b1;
      end else if (reset_held) begin
         hi_latch <= 1'b0;
      end
   end

   // low pressure latch; the dump valve pulls pressure down so it follows a high alarm
   always_ff @(posedge clk) begin
      if (rst) begin
         lo_latch <= 1'b0;
      end else if (filt[IN_LOW]) begin
         lo_latch <= 1'b1;
      end else if (reset_held && !filt[IN_HIGH]) begin
         lo_latch <= 1'b0;
      end
   end

   // power failure latch on the falling mains level; a new failure beats the reset
   always_ff @(posedge clk) begin
      if (rst) begin
         pf_latch <= 1'b0;
      end else if (pf_new) begin
         pf_latch <= 1'b1;
      end else if (reset_held) begin
         pf_latch <= 1'b0;
      end
   end

   // start/stop toggle; a new high, low or power alarm drops the enable so a fresh start is needed
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_enabled <= 1'b0;
      end else if (hi_new || lo_new || pf_new) begin
         osc_enabled <= 1'b0;
      end else if (start_press) begin
         if (osc_enabled) begin
            osc_enabled <= 1'b0;
         end else if (filt[IN_STARTUP_OK] && !pf_latch
                      && (!(hi_latch || lo_latch) || reset_held)) begin
            osc_enabled <= 1'b1;
         end
      end
   end

   // valve and drive commands; the dump closes only while recovery is held
   always_ff @(posedge clk) begin
      if (rst) begin
         osc_drive <= 1'b0;
         dump_open <= 1'b0;
         bias_flow <= 1'b1;
      end else begin
         osc_drive <= osc_enabled & ~hi_latch & ~lo_latch & ~pf_latch;
         dump_open <= (hi_latch | lo_latch)
                      & ~(reset_held & osc_enabled & ~filt[IN_HIGH]);
         bias_flow <= 1'b1;
      end
   end

   // lamps; cautions follow their sensors (battery lamp also lit while reset is held) and never reach the tone
   always_ff @(posedge clk) begin
      if (rst) begin
         red_high <= 1'b0;
         red_low <= 1'b0;
         red_power <= 1'b0;
         red_stopped <= 1'b0;
         yel_gas <= 1'b0;
         yel_batt <= 1'b0;
         yel_hot <= 1'b0;
         yel_silence <= 1'b0;
      end else begin
         red_high <= hi_latch;
         red_low <= lo_latch;
         red_power <= pf_latch;
         red_stopped <= osc_enabled & filt[IN_AMP];
         yel_gas <= filt[IN_GAS_BLEND] | filt[IN_GAS_COOL];
         yel_batt <= filt[IN_BATT] | reset_held;
         yel_hot <= filt[IN_HOT];
         yel_silence <= sil_active;
      end
   end

   // millisecond tick; all long intervals count ticks, keeping counters narrow in use
   always_ff @(posedge clk) begin
      if (rst) begin
         tick_cnt <= 32'h0;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
         tick_cnt <= 32'h0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   // silence interval; a press while running is ignored, nothing can stop it early
   always_ff @(posedge clk) begin
      if (rst) begin
         sil_active <= 1'b0;
         sil_cnt <= 32'h0;
         sil_done <= 1'b0;
      end else begin
         sil_done <= 1'b0;
         if (!sil_active) begin
            if (sil_press) begin
               sil_active <= 1'b1;
               sil_cnt <= 32'(SIL_TICKS - 1);
            end
         end else if (tick) begin
            if (sil_cnt == 32'h0) begin
               sil_active <= 1'b0;
               sil_done <= 1'b1;
            end else begin
               sil_cnt <= sil_cnt - 32'h1;
            end
         end
      end
   end

   // 3 kHz carrier and the slower on/off modulation
   always_ff @(posedge clk) begin
      if (rst) begin
         tone_cnt <= 32'h0;
         sq <= 1'b0;
      end else if (tone_cnt == 32'(TONE_HALF - 1)) begin
         tone_cnt <= 32'h0;
         sq <= ~sq;
      end else begin
         tone_cnt <= tone_cnt + 32'h1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         mod_cnt <= 32'h0;
         mod_phase <= 1'b1;
      end else if (tick) begin
         if (mod_cnt == 32'(MOD_LEN - 1)) begin
            mod_cnt <= 32'h0;
            mod_phase <= ~mod_phase;
         end else begin
            mod_cnt <= mod_cnt + 32'h1;
         end
      end
   end

   // tone only for red alarms; silence mutes the sound, never the lamps
   always_ff @(posedge clk) begin
      if (rst) begin
         tone <= 1'b0;
      end else begin
         tone <= any_red & ~sil_active & sq
                 & (mod_phase | ~ctrl[CTRL_MOD_BIT]);
      end
   end

   // sticky event bits; a new event in the clearing cycle survives
   assign events = {sil_done, caution & ~(filt_q[IN_GAS_BLEND] | filt_q[IN_GAS_COOL]
                    | filt_q[IN_BATT] | filt_q[IN_HOT]),
                    osc_enabled & filt[IN_AMP] & ~red_stopped, pf_new, lo_new, hi_new};
   assign clr_mask = (do_write && aw_addr == IRQ_CLEAR_OFS && w_strb[0])
                     ? w_data[NUM_EV-1:0] : '0;

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= '0;
         irq <= 1'b0;
      end else begin
         irq_status <= (irq_status & ~clr_mask) | events;
         irq <= |(irq_status & irq_en);
      end
   end

   // write channels are taken independently and held until the response completes
   assign do_write = aw_got & w_got & ~bvalid;

   always_ff @(posedge clk) begin
      if (rst) begin
         awready <= 1'b1;
         aw_got <= 1'b0;
         aw_addr <= 8'h00;
      end else if (awvalid && awready) begin
         awready <= 1'b0;
         aw_got <= 1'b1;
         aw_addr <= awaddr;
      end else if (do_write) begin
         aw_got <= 1'b0;
      end else if (bvalid && bready) begin
         awready <= 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wready <= 1'b1;
         w_got <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
      end else if (wvalid && wready) begin
         wready <= 1'b0;
         w_got <= 1'b1;
         w_data <= wdata;
         w_strb <= wstrb;
      end else if (do_write) begin
         w_got <= 1'b0;
      end else if (bvalid && bready) begin
         wready <= 1'b1;
      end
   end

   // register updates and write response; only byte lane 0 carries bits
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl <= CTRL_RST;
         irq_en <= IRQ_ENABLE_RST;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else if (do_write) begin
         bvalid <= 1'b1;
         bresp <= (aw_addr == LIVE_OFS || aw_addr == CTRL_OFS || aw_addr == IRQ_STATUS_OFS
                   || aw_addr == IRQ_ENABLE_OFS || aw_addr == IRQ_CLEAR_OFS)
                  ? RESP_OKAY : RESP_DECERR;
         if (aw_addr == CTRL_OFS && w_strb[0]) begin
            ctrl <= {31'h0, w_data[CTRL_MOD_BIT]};
         end
         if (aw_addr == IRQ_ENABLE_OFS && w_strb[0]) begin
            irq_en <= w_data[NUM_EV-1:0];
         end
      end else if (bvalid && bready) begin
         bvalid <= 1'b0;
      end
   end

   // reads answer one cycle after the address is taken
   always_ff @(posedge clk) begin
      if (rst) begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h0;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rresp <= RESP_OKAY;
         unique case (araddr)
            LIVE_OFS: rdata <= {16'h0, yel_silence, yel_hot, yel_batt, yel_gas, red_stopped,
                                pf_latch, lo_latch, hi_latch, 4'h0, sil_active, dump_open,
                                osc_drive, osc_enabled};
            CTRL_OFS: rdata <= ctrl;
            IRQ_STATUS_OFS: rdata <= {26'h0, irq_status};
            IRQ_ENABLE_OFS: rdata <= {26'h0, irq_en};
            IRQ_CLEAR_OFS: rdata <= 32'h0;
            default: begin
               rdata <= 32'h0;
               rresp <= RESP_DECERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
         arready <= 1'b1;
      end
   end

   // checks beside the logic
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence sil_start;
      sil_press && !sil_active;
   endsequence

   sequence high_seen;
      filt[IN_HIGH] ##1 hi_latch;
   endsequence

   a_high_latch_hold: assert property (hi_latch && !reset_held |=> hi_latch)
      else $error("high alarm dropped without reset");
   a_high_stops_osc: assert property (high_seen |=> !osc_drive && red_high)
      else $error("oscillator still driven in high alarm");
   a_dump_holds_high: assert property (filt[IN_HIGH] && hi_latch |=> dump_open)
      else $error("dump valve closed while high pressure present");
   a_low_lamp_on: assert property (filt[IN_LOW] |-> ##2 red_low)
      else $error("low pressure lamp missing");
   a_power_reset: assert property (pf_latch && reset_held && !pf_new |=> !pf_latch)
      else $error("power alarm not cleared by reset");
   a_start_refused: assert property (start_press && !osc_enabled && !filt[IN_STARTUP_OK]
                                     |=> !osc_enabled)
      else $error("oscillator enabled without start-up conditions");
   a_silence_span: assert property (sil_start |=> sil_active [*8])
      else $error("silence interval ended early");
   a_silence_mutes: assert property (sil_active |=> !tone)
      else $error("tone sounding during silence");
   a_tone_red_only: assert property (tone |-> $past(any_red))
      else $error("tone without a red alarm");
   a_stopped_lamp: assert property (osc_enabled && filt[IN_AMP] |=> red_stopped)
      else $error("oscillator stopped lamp missing");
endmodule
`default_nettype wire

// ---- test/pressure_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module pressure_model #(
   parameter int LAG = 6
) (
   input wire logic clk, // system clock
   input wire logic high_cond, // over-pressure present in the circuit
   input wire logic leak_cond, // leak holds mean pressure down by itself
   input wire logic dump_open, // dump valve command from the supervisor
   output logic press_high, // comparator: above 60
   output logic press_low // comparator: mean_airway_pressure below 5
);
   logic vented = 1'b0;
   int cnt = 0;
   // the circuit needs a few cycles to vent or to rebuild after the valve moves
   always_ff @(posedge clk) begin
      if (dump_open == vented) begin
         cnt <= 0;
      end else if (cnt == LAG) begin
         vented <= dump_open;
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
   // an open dump valve drops the airway to near atmospheric
   assign press_low = leak_cond | vented;
   assign press_high = high_cond;
endmodule
`default_nettype wire

// ---- test/ventilator_alarm_supervisor_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module ventilator_alarm_supervisor_tb;
   import alarm_pkg::*;
   logic clk = 0, rst = 1, high_cond = 0, leak_cond = 0, mains_ok = 1, su_ok = 0;
   logic gas_b = 0, gas_c = 0, batt = 0, hot = 0, amp = 0;
   logic [2:0] btn = 3'h0; // reset, start, silence
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic press_high, press_low, osc_drive, osc_enabled, dump_open, bias_flow;
   logic red_high, red_low, red_power, red_stopped, yel_gas, yel_batt, yel_hot, yel_silence;
   logic tone, irq, awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata, rd;
   int n_fail = 0, checked = 0, cyc = 0, n;
   always #5 clk = ~clk;
   pressure_model #(.LAG(6)) pressure_model_i (.clk(clk), .high_cond(high_cond),
      .leak_cond(leak_cond), .dump_open(dump_open), .press_high(press_high),
      .press_low(press_low));
   // short counts keep the 45 s interval at 200 cycles
   alarm_supervisor #(.TICK_CYC(10), .SIL_TICKS(20), .TONE_HALF(3), .MOD_LEN(2))
      alarm_supervisor_i (.clk(clk), .rst(rst), .press_high(press_high),
      .press_low(press_low), .mains_ok(mains_ok), .gas_low_blend(gas_b),
      .gas_low_cool(gas_c), .batt_low(batt), .coil_hot(hot), .amp_low(amp),
      .btn_reset(btn[0]), .btn_start(btn[1]), .btn_silence(btn[2]), .startup_ok(su_ok),
      .osc_drive(osc_drive), .osc_enabled(osc_enabled), .dump_open(dump_open),
      .bias_flow(bias_flow), .red_high(red_high), .red_low(red_low), .red_power(red_power),
      .red_stopped(red_stopped), .yel_gas(yel_gas), .yel_batt(yel_batt), .yel_hot(yel_hot),
      .yel_silence(yel_silence), .tone(tone), .irq(irq), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
      .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
      .rready(rready));
   task automatic end_sim;
      if (n_fail == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // a hang counts as a failure and closes the run
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim;
      end
   end
   task automatic tick(input int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
      end
   endtask
   // address and data offered together, each dropped when its own ready is seen
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1;
      wvalid <= 1;
      bready <= 1;
      do begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 0;
         if (wvalid && wready) wvalid <= 0;
      end while (!bvalid);
      rs = bresp;
      bready <= 0;
   endtask
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      araddr <= a;
      arvalid <= 1;
      rready <= 1;
      do begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 0;
      end while (!rvalid);
      d = rdata;
      r = rresp;
      rready <= 0;
   endtask
   // buttons are held long enough to pass the input filter
   task automatic push(input int i);
      btn[i] <= 1;
      tick(6);
      btn[i] <= 0;
      tick(8);
   endtask
   task automatic tone_rises(input int k, output int c);
      logic prev;
      c = 0;
      prev = tone;
      repeat (k) begin
         @(posedge clk);
         if (tone && !prev) c++;
         prev = tone;
      end
   endtask
   // operator holds reset with the oscillator restarted until pressure rebuilds
   task automatic recover;
      btn[0] <= 1;
      tick(6);
      push(1);
      chk_bit(osc_enabled, 1);
      tick(30);
      chk_bit(dump_open, 0);
      chk_bit(red_high, 0);
      chk_bit(red_low, 0);
      chk_bit(yel_batt, 1);
      btn[0] <= 0;
      tick(8);
      chk_bit(osc_drive, 1);
      chk_bit(yel_batt, 0);
   endtask
   initial begin
      tick(10);
      rst <= 0;
      tick(2);
      chk_bit(bias_flow, 1);
      axi_rd(CTRL_OFS, rd, rs);
      chk_word(rd, CTRL_RST);
      axi_rd(IRQ_ENABLE_OFS, rd, rs);
      chk_word(rd, 32'(IRQ_ENABLE_RST));
      axi_rd(8'h40, rd, rs);
      chk_word(32'(rs), 32'(RESP_DECERR));
      push(1);
      chk_bit(osc_enabled, 0);
      su_ok <= 1;
      push(1);
      chk_bit(osc_enabled, 1);
      chk_bit(osc_drive, 1);
      axi_rd(LIVE_OFS, rd, rs);
      chk_word(rd, 32'h3);
      axi_wr(8'h40, 32'h0);
      chk_word(32'(rs), 32'(RESP_DECERR));
      axi_wr(IRQ_ENABLE_OFS, 32'h1);
      chk_word(32'(rs), 32'(RESP_OKAY));
      // over-pressure trips the high alarm, venting then trips the low one
      high_cond <= 1;
      tick(8);
      chk_bit(red_high, 1);
      chk_bit(osc_drive, 0);
      chk_bit(dump_open, 1);
      chk_bit(bias_flow, 1);
      chk_bit(irq, 1);
      tick(14);
      chk_bit(red_low, 1);
      tone_rises(100, n);
      chk_bit(n > 0, 1);
      axi_rd(IRQ_STATUS_OFS, rd, rs);
      chk_word(rd & 32'h3, 32'h3);
      axi_wr(IRQ_CLEAR_OFS, 32'h3);
      tick(2);
      chk_bit(irq, 0);
      // silence mutes only the tone; a second press must not restart it
      push(2);
      chk_bit(yel_silence, 1);
      tone_rises(60, n);
      chk_bit(n == 0, 1);
      chk_bit(red_high, 1);
      chk_bit(dump_open, 1);
      chk_bit(red_low, 1);
      push(2);
      tick(80);
      chk_bit(yel_silence, 1);
      tick(70);
      chk_bit(yel_silence, 0);
      tone_rises(60, n);
      chk_bit(n > 0, 1);
      push(0);
      chk_bit(red_high, 1);
      high_cond <= 0;
      tick(8);
      chk_bit(red_high, 1);
      recover;
      // modulation off gives a continuous carrier
      axi_wr(CTRL_OFS, 32'h0);
      axi_rd(CTRL_OFS, rd, rs);
      chk_word(rd, 32'h0);
      amp <= 1;
      tick(8);
      chk_bit(red_stopped, 1);
      chk_bit(osc_drive, 1);
      chk_bit(dump_open, 0);
      tone_rises(60, n);
      chk_bit(n >= 9, 1);
      amp <= 0;
      tick(8);
      chk_bit(red_stopped, 0);
      axi_wr(CTRL_OFS, 32'h1);
      axi_rd(IRQ_STATUS_OFS, rd, rs);
      chk_word(rd & 32'h28, 32'h28);
      // a leak alone raises the low alarm
      leak_cond <= 1;
      tick(8);
      chk_bit(red_low, 1);
      chk_bit(osc_drive, 0);
      chk_bit(dump_open, 1);
      chk_bit(bias_flow, 1);
      // the leak ends only once venting holds the pressure down
      tick(8);
      leak_cond <= 0;
      recover;
      // power failure stays latched and its event is masked
      axi_wr(IRQ_CLEAR_OFS, 32'h3f);
      mains_ok <= 0;
      tick(8);
      chk_bit(red_power, 1);
      chk_bit(osc_drive, 0);
      chk_bit(irq, 0);
      axi_rd(IRQ_STATUS_OFS, rd, rs);
      chk_word(rd & 32'h4, 32'h4);
      mains_ok <= 1;
      tick(8);
      chk_bit(red_power, 1);
      push(0);
      chk_bit(red_power, 0);
      chk_bit(osc_enabled, 0);
      push(1);
      chk_bit(osc_enabled, 1);
      // cautions light yellow only, with no tone
      gas_b <= 1;
      tick(8);
      chk_bit(yel_gas, 1);
      gas_b <= 0;
      gas_c <= 1;
      tick(8);
      chk_bit(yel_gas, 1);
      hot <= 1;
      batt <= 1;
      tick(8);
      chk_bit(yel_hot, 1);
      chk_bit(yel_batt, 1);
      tone_rises(60, n);
      chk_bit(n == 0, 1);
      gas_c <= 0;
      hot <= 0;
      batt <= 0;
      tick(8);
      chk_bit(yel_gas, 0);
      chk_bit(yel_hot, 0);
      chk_bit(yel_batt, 0);
      axi_rd(IRQ_STATUS_OFS, rd, rs);
      chk_word(rd & 32'h10, 32'h10);
      end_sim;
   end
endmodule
`default_nettype wire
